// ===== cbd_config_byte_decoder.sv
// module: configuration byte loader and decoder with apb access
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
module cbd_config_byte_decoder (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // configuration flash read port
    output logic flash_req,
    output logic [1:0] flash_index,
    input wire logic [7:0] flash_rdata,
    input wire logic flash_ack,
    // core reset release
    output logic core_release,
    // brown-out detector
    input wire logic supply_low,
    output logic brownout_detect_on,
    output logic [1:0] brownout_threshold_select,
    output logic [12:0] brownout_threshold_mv,
    output logic brownout_reset_req,
    output logic flash_program_inhibit,
    // converter
    input wire logic conv_done,
    input wire logic conv_compare_mode,
    input wire logic conv_compare_match,
    output logic converter_done_flag_set,
    // watchdog
    output logic watchdog_reset_enable,
    output logic watchdog_halt_in_sleep,
    output logic watchdog_timer_free
);

    cbd_pkg::cbd_state_t st_r;
    cbd_pkg::cbd_state_t st_nxt;

    logic setup_phase;
    logic write_taken;
    logic bo_detect;
    logic bo_inhibit;
    logic bo_reset_en;
    logic [1:0] bo_thr;
    logic cv_match_only;
    logic [3:0] wd_policy;
    logic [31:0] status_word;

    assign setup_phase = psel & ~penable;
    assign write_taken = psel & penable & pwrite & pstrb[0];

    assign bo_detect = st_r.bo_byte[cbd_pkg::CBD_BO_DETECT_ENABLE_BIT];
    assign bo_inhibit = st_r.bo_byte[cbd_pkg::CBD_BO_FLASH_INHIBIT_BIT];
    assign bo_reset_en = st_r.bo_byte[cbd_pkg::CBD_BO_RESET_ENABLE_BIT];
    assign bo_thr = st_r.bo_byte[cbd_pkg::CBD_BO_THRESHOLD_LSB +: 2];
    assign cv_match_only = st_r.cv_byte[cbd_pkg::CBD_CV_MATCH_ONLY_BIT];
    assign wd_policy = st_r.wd_byte[cbd_pkg::CBD_WD_POLICY_LSB +: 4];

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[cbd_pkg::CBD_ST_LOADED_BIT] = st_r.core_release;
        status_word[cbd_pkg::CBD_ST_SUPPLY_LOW_BIT] = supply_low;
        status_word[cbd_pkg::CBD_ST_INHIBIT_BIT] = st_r.flash_inhibit;
        status_word[cbd_pkg::CBD_ST_BOD_RESET_BIT] = st_r.bod_reset;
    end

    always_comb begin
        st_nxt = st_r;

        // flash image load after reset; the core stays held until the last byte lands
        unique case (st_r.state)
            cbd_pkg::CBD_LD_BROWNOUT: begin
                if (flash_ack) begin
                    st_nxt.bo_byte = flash_rdata & cbd_pkg::CBD_BO_MASK;
                    st_nxt.state = cbd_pkg::CBD_LD_CONVERTER;
                end
            end
            cbd_pkg::CBD_LD_CONVERTER: begin
                if (flash_ack) begin
                    st_nxt.cv_byte = flash_rdata & cbd_pkg::CBD_CV_MASK;
                    st_nxt.state = cbd_pkg::CBD_LD_WATCHDOG;
                end
            end
            cbd_pkg::CBD_LD_WATCHDOG: begin
                if (flash_ack) begin
                    st_nxt.wd_byte = flash_rdata & cbd_pkg::CBD_WD_MASK;
                    st_nxt.state = cbd_pkg::CBD_LD_RUN;
                    st_nxt.core_release = 1'b1;
                end
            end
            cbd_pkg::CBD_LD_RUN: begin
                // software writes only after load, so a late write cannot be overwritten
                if (write_taken) begin
                    unique case (paddr)
                        cbd_pkg::CBD_OFF_BROWNOUT:
                            st_nxt.bo_byte = pwdata[7:0] & cbd_pkg::CBD_BO_MASK;
                        cbd_pkg::CBD_OFF_CONVERTER:
                            st_nxt.cv_byte = pwdata[7:0] & cbd_pkg::CBD_CV_MASK;
                        cbd_pkg::CBD_OFF_WATCHDOG:
                            st_nxt.wd_byte = pwdata[7:0] & cbd_pkg::CBD_WD_MASK;
                        default: begin
                        end
                    endcase
                end
            end
        endcase

        // read data is captured in the setup phase so the access phase needs no wait
        if (setup_phase) begin
            st_nxt.pslverr = 1'b0;
            unique case (paddr)
                cbd_pkg::CBD_OFF_BROWNOUT: st_nxt.prdata = {24'h000000, st_r.bo_byte};
                cbd_pkg::CBD_OFF_CONVERTER: st_nxt.prdata = {24'h000000, st_r.cv_byte};
                cbd_pkg::CBD_OFF_WATCHDOG: st_nxt.prdata = {24'h000000, st_r.wd_byte};
                cbd_pkg::CBD_OFF_STATUS: begin
                    st_nxt.prdata = status_word;
                    st_nxt.pslverr = pwrite;
                end
                default: begin
                    st_nxt.prdata = 32'h0000_0000;
                    st_nxt.pslverr = 1'b1;
                end
            endcase
        end

        // inhibit and brown-out reset need the detector running
        st_nxt.flash_inhibit = bo_detect & bo_inhibit & supply_low;
        st_nxt.bod_reset = bo_detect & bo_reset_en & supply_low;

        // flag on every conversion, or only on a match in compare mode
        st_nxt.conv_flag = conv_done &
            (~cv_match_only | ~conv_compare_mode | conv_compare_match);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r.state <= cbd_pkg::CBD_LD_BROWNOUT;
            st_r.bo_byte <= cbd_pkg::CBD_BO_RESET;
            st_r.cv_byte <= cbd_pkg::CBD_CV_RESET;
            st_r.wd_byte <= cbd_pkg::CBD_WD_RESET;
            st_r.prdata <= 32'h0000_0000;
            st_r.pslverr <= 1'b0;
            st_r.conv_flag <= 1'b0;
            st_r.flash_inhibit <= 1'b0;
            st_r.bod_reset <= 1'b0;
            st_r.core_release <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // apb answers: zero wait states
    assign pready = 1'b1;
    assign prdata = st_r.prdata;
    assign pslverr = st_r.pslverr & psel & penable;

    // flash request stays high through the whole load, until the acknowledge of the watchdog byte
    assign flash_req = (st_r.state != cbd_pkg::CBD_LD_RUN);
    always_comb begin
        unique case (st_r.state)
            cbd_pkg::CBD_LD_CONVERTER: flash_index = cbd_pkg::CBD_FLASH_IDX_CONVERTER;
            cbd_pkg::CBD_LD_WATCHDOG: flash_index = cbd_pkg::CBD_FLASH_IDX_WATCHDOG;
            default: flash_index = cbd_pkg::CBD_FLASH_IDX_BROWNOUT;
        endcase
    end

    assign core_release = st_r.core_release;

    // brown-out settings
    assign brownout_detect_on = bo_detect;
    assign brownout_threshold_select = bo_thr;
    always_comb begin
        unique case (bo_thr)
            cbd_pkg::CBD_THR_CODE_2V2: brownout_threshold_mv = cbd_pkg::CBD_THR_MV_2V2;
            cbd_pkg::CBD_THR_CODE_2V7: brownout_threshold_mv = cbd_pkg::CBD_THR_MV_2V7;
            cbd_pkg::CBD_THR_CODE_3V7: brownout_threshold_mv = cbd_pkg::CBD_THR_MV_3V7;
            cbd_pkg::CBD_THR_CODE_4V4: brownout_threshold_mv = cbd_pkg::CBD_THR_MV_4V4;
        endcase
    end
    assign brownout_reset_req = st_r.bod_reset;
    assign flash_program_inhibit = st_r.flash_inhibit;

    assign converter_done_flag_set = st_r.conv_flag;

    // watchdog policy decode
    assign watchdog_timer_free = (wd_policy == cbd_pkg::CBD_WD_POLICY_TIMER);
    assign watchdog_reset_enable = (wd_policy != cbd_pkg::CBD_WD_POLICY_TIMER);
    assign watchdog_halt_in_sleep = (wd_policy == cbd_pkg::CBD_WD_POLICY_STOP_IDLE);

endmodule

// ===== cbd_config_byte_decoder_chk.sv
// assertion checker for the configuration byte decoder ports
`timescale 1ns/1ps
module cbd_chk (
    // clock, reset and apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pslverr,
    // flash load and core release
    input wire logic flash_req,
    input wire logic flash_ack,
    input wire logic core_release,
    // brown-out
    input wire logic supply_low,
    input wire logic brownout_detect_on,
    input wire logic brownout_reset_req,
    input wire logic flash_program_inhibit,
    input wire logic [1:0] brownout_threshold_select,
    input wire logic [12:0] brownout_threshold_mv,
    // converter
    input wire logic conv_done,
    input wire logic conv_compare_mode,
    input wire logic converter_done_flag_set,
    // watchdog
    input wire logic watchdog_reset_enable,
    input wire logic watchdog_halt_in_sleep,
    input wire logic watchdog_timer_free
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    AST_ERR_IN_ACCESS: assert property (pslverr |-> psel && penable)
        else $error("error flag outside access phase");
    AST_THR_DECODE: assert property (brownout_threshold_mv == (
        brownout_threshold_select == 2'h3 ? 13'h0898 : brownout_threshold_select == 2'h2 ?
        13'h0A8C : brownout_threshold_select == 2'h1 ? 13'h0E74 : 13'h1130))
        else $error("threshold level wrong");
    AST_INHIBIT_CAUSE: assert property (
        flash_program_inhibit |-> $past(supply_low) && $past(brownout_detect_on))
        else $error("inhibit without low supply and detector");
    AST_BOR_CAUSE: assert property (
        brownout_reset_req |-> $past(supply_low) && $past(brownout_detect_on))
        else $error("brown-out reset without cause");
    AST_FLAG_CAUSE: assert property (converter_done_flag_set |-> $past(conv_done))
        else $error("done flag without conversion end");
    AST_FLAG_PLAIN: assert property (conv_done && !conv_compare_mode |=> converter_done_flag_set)
        else $error("done flag missing");
    AST_WDT_FREE: assert property (watchdog_timer_free != watchdog_reset_enable)
        else $error("watchdog free and reset both or neither");
    AST_WDT_HALT: assert property (watchdog_halt_in_sleep |-> watchdog_reset_enable)
        else $error("halting watchdog without reset");
    AST_LOAD_ORDER: assert property ($rose(core_release) |-> $past(flash_ack) && !flash_req)
        else $error("core released before last byte");
    AST_HOLD_CORE: assert property (flash_req |-> !core_release)
        else $error("core released while loading");
endmodule

bind cbd_config_byte_decoder cbd_chk u_chk (.*);

// ===== cbd_config_byte_decoder_tb_top.sv
// self-checking testbench for the configuration byte decoder
`timescale 1ns/1ps
module cbd_config_byte_decoder_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, lag;
    logic flash_req, flash_ack, core_release, supply_low;
    logic [1:0] flash_index, brownout_threshold_select;
    logic [7:0] flash_rdata;
    logic [23:0] image;
    logic brownout_detect_on, brownout_reset_req, flash_program_inhibit;
    logic [12:0] brownout_threshold_mv;
    logic conv_done, conv_compare_mode, conv_compare_match, converter_done_flag_set;
    logic watchdog_reset_enable, watchdog_halt_in_sleep, watchdog_timer_free;
    int n_mismatch, cmp_count, cyc;
    cbd_config_byte_decoder DUT (.*);
    cbd_flash_model u_flash (.*);
    initial begin
        pclk = 1'h0;
        forever #2 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic do_reset(input logic [3:0] l);
        lag <= l;
        presetn <= 1'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        while (core_release !== 1'h1) @(posedge pclk);
    endtask
    task automatic t_load;
        do_reset(4'h3);
        chk({brownout_detect_on, brownout_threshold_select}, 3'h7);
        chk(watchdog_halt_in_sleep, 1'h1);
        apb(1'h0, cbd_pkg::CBD_OFF_BROWNOUT, 32'h0);
        chk(rd, 32'hB4);
        apb(1'h0, cbd_pkg::CBD_OFF_WATCHDOG, 32'h0);
        chk(rd, 32'h50);
        apb(1'h1, cbd_pkg::CBD_OFF_BROWNOUT, 32'h0);
        apb(1'h0, cbd_pkg::CBD_OFF_BROWNOUT, 32'h0);
        chk(rd, 32'h0);
        do_reset(4'h0);
        apb(1'h0, cbd_pkg::CBD_OFF_BROWNOUT, 32'h0);
        chk(rd, 32'hB4);
    endtask
    task automatic t_bod;
        logic [12:0] mv [4] = '{13'h1130, 13'h0E74, 13'h0A8C, 13'h0898};
        for (int i = 0; i < 4; i++) begin
            apb(1'h1, cbd_pkg::CBD_OFF_BROWNOUT, 32'h8C | (i << 4));
            @(posedge pclk);
            chk(brownout_threshold_mv, mv[i]);
        end
        supply_low <= 1'h1;
        repeat (2) @(posedge pclk);
        chk({brownout_reset_req, flash_program_inhibit}, 2'h3);
        apb(1'h1, cbd_pkg::CBD_OFF_BROWNOUT, 32'h0C);
        repeat (2) @(posedge pclk);
        chk({brownout_detect_on, brownout_reset_req, flash_program_inhibit}, 3'h0);
        apb(1'h1, cbd_pkg::CBD_OFF_BROWNOUT, 32'hB0);
        repeat (2) @(posedge pclk);
        chk({brownout_reset_req, flash_program_inhibit}, 2'h0);
        supply_low <= 1'h0;
    endtask
    task automatic pulse(input logic mode, input logic match, input logic exp);
        conv_compare_mode <= mode;
        conv_compare_match <= match;
        conv_done <= 1'h1;
        @(posedge pclk);
        conv_done <= 1'h0;
        @(posedge pclk);
        chk(converter_done_flag_set, exp);
    endtask
    task automatic t_conv;
        apb(1'h1, cbd_pkg::CBD_OFF_CONVERTER, 32'h08);
        pulse(1'h1, 1'h0, 1'h0);
        pulse(1'h1, 1'h1, 1'h1);
        pulse(1'h0, 1'h0, 1'h1);
        apb(1'h1, cbd_pkg::CBD_OFF_CONVERTER, 32'hF7);
        pulse(1'h1, 1'h0, 1'h1);
    endtask
    task automatic t_wdt;
        logic [3:0] pol [4] = '{4'hF, 4'h5, 4'h3, 4'h0};
        for (int i = 0; i < 4; i++) begin
            apb(1'h1, cbd_pkg::CBD_OFF_WATCHDOG, {24'h0, pol[i], 4'hF});
            @(posedge pclk);
            chk({watchdog_reset_enable, watchdog_halt_in_sleep, watchdog_timer_free},
                {pol[i] != 4'hF, pol[i] == 4'h5, pol[i] == 4'hF});
        end
        // unmapped read and status write are refused; status read shows the load done
        apb(1'h0, 12'h010, 32'h0);
        chk(rd, 32'h0);
        chk(err, 1'h1);
        apb(1'h1, cbd_pkg::CBD_OFF_STATUS, 32'h0);
        chk(err, 1'h1);
        apb(1'h0, cbd_pkg::CBD_OFF_STATUS, 32'h0);
        chk(rd, 32'h1);
        chk(err, 1'h0);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    initial begin
        {psel, penable, pwrite, supply_low, conv_done, conv_compare_mode, conv_compare_match} = 7'h00;
        {paddr, pwdata, pstrb, presetn, lag, image} = {12'h000, 32'h0, 4'hF, 1'h0, 4'h3, 24'h5A08B4};
        t_load();
        $display("finished load");
        t_bod();
        $display("finished brown-out");
        t_conv();
        $display("finished converter");
        t_wdt();
        $display("finished watchdog");
        print_verdict();
    end
endmodule

// ===== cbd_flash_model.sv
// model of the configuration flash that answers the decoder's byte reads
`timescale 1ns/1ps
module cbd_flash_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // byte read port
    input wire logic flash_req,
    input wire logic [1:0] flash_index,
    output logic [7:0] flash_rdata,
    output logic flash_ack,
    // stored image and answer delay
    input wire logic [23:0] image,
    input wire logic [3:0] lag
);
    logic [3:0] cnt;
    logic [7:0] pick;
    // reserved bits stay unprogrammed, so they read as ones
    always_comb begin
        pick = flash_index == 2'h0 ? image[7:0] | 8'h43 :
               flash_index == 2'h1 ? image[15:8] | 8'hF7 : image[23:16] | 8'h0F;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 4'h0;
            flash_ack <= 1'h0;
            flash_rdata <= 8'h5A;
        end else if (flash_req && !flash_ack && cnt >= lag) begin
            cnt <= 4'h0;
            flash_ack <= 1'h1;
            flash_rdata <= pick;
        end else begin
            cnt <= (flash_req && !flash_ack) ? cnt + 4'h1 : 4'h0;
            flash_ack <= 1'h0;
            // data is only valid with ack, so keep it moving otherwise
            flash_rdata <= ~flash_rdata;
        end
    end
endmodule

// ===== cbd_pkg.sv
// package: constants and types for the configuration byte decoder
package cbd_pkg;

    // apb register byte offsets
    localparam logic [11:0] CBD_OFF_BROWNOUT = 12'h000;
    localparam logic [11:0] CBD_OFF_CONVERTER = 12'h004;
    localparam logic [11:0] CBD_OFF_WATCHDOG = 12'h008;
    localparam logic [11:0] CBD_OFF_STATUS = 12'h00C;

    // flash index of each configuration byte
    localparam logic [1:0] CBD_FLASH_IDX_BROWNOUT = 2'h0;
    localparam logic [1:0] CBD_FLASH_IDX_CONVERTER = 2'h1;
    localparam logic [1:0] CBD_FLASH_IDX_WATCHDOG = 2'h2;

    // brownout_config_byte fields
    localparam int CBD_BO_DETECT_ENABLE_BIT = 7;
    localparam int CBD_BO_THRESHOLD_LSB = 4;
    localparam int CBD_BO_FLASH_INHIBIT_BIT = 3;
    localparam int CBD_BO_RESET_ENABLE_BIT = 2;
    localparam logic [7:0] CBD_BO_MASK = 8'hBC;

    // converter_flag_config_byte fields
    localparam int CBD_CV_MATCH_ONLY_BIT = 3;
    localparam logic [7:0] CBD_CV_MASK = 8'h08;

    // watchdog_config_byte fields
    localparam int CBD_WD_POLICY_LSB = 4;
    localparam logic [7:0] CBD_WD_MASK = 8'hF0;
    localparam logic [3:0] CBD_WD_POLICY_TIMER = 4'hF;
    localparam logic [3:0] CBD_WD_POLICY_STOP_IDLE = 4'h5;

    // values after reset, before the flash image is loaded: brown-out and match-only off, watchdog as a free timer without reset
    localparam logic [7:0] CBD_BO_RESET = 8'h00;
    localparam logic [7:0] CBD_CV_RESET = 8'h00;
    localparam logic [7:0] CBD_WD_RESET = 8'hF0;

    // brown-out threshold codes and their levels in millivolts
    localparam logic [1:0] CBD_THR_CODE_2V2 = 2'h3;
    localparam logic [1:0] CBD_THR_CODE_2V7 = 2'h2;
    localparam logic [1:0] CBD_THR_CODE_3V7 = 2'h1;
    localparam logic [1:0] CBD_THR_CODE_4V4 = 2'h0;
    localparam logic [12:0] CBD_THR_MV_2V2 = 13'h0898;
    localparam logic [12:0] CBD_THR_MV_2V7 = 13'h0A8C;
    localparam logic [12:0] CBD_THR_MV_3V7 = 13'h0E74;
    localparam logic [12:0] CBD_THR_MV_4V4 = 13'h1130;

    // status register bits
    localparam int CBD_ST_LOADED_BIT = 0;
    localparam int CBD_ST_SUPPLY_LOW_BIT = 1;
    localparam int CBD_ST_INHIBIT_BIT = 2;
    localparam int CBD_ST_BOD_RESET_BIT = 3;

    typedef enum logic [1:0] {
        CBD_LD_BROWNOUT,
        CBD_LD_CONVERTER,
        CBD_LD_WATCHDOG,
        CBD_LD_RUN
    } cbd_load_state_t;

    typedef struct packed {
        cbd_load_state_t state;
        logic [7:0] bo_byte;
        logic [7:0] cv_byte;
        logic [7:0] wd_byte;
        logic [31:0] prdata;
        logic pslverr;
        logic conv_flag;
        logic flash_inhibit;
        logic bod_reset;
        logic core_release;
    } cbd_state_t;

endpackage
